// ---- include/sas_pkg.sv ----
/*
 * shared constants for the successive-approximation converter sequencer:
 * register addresses, field positions, reset values and machine-cycle counts.
 * assumes an 8-bit special function register space.
 */
package sas_pkg;
   localparam int SAS_DATA_W = 8;
   localparam logic [7:0] SAS_ADDR_CONVERTER_CONTROL = 8'hD8;
   localparam logic [7:0] SAS_ADDR_CONVERSION_RESULT = 8'hD9;
   localparam logic [7:0] SAS_ADDR_REFERENCE_PROGRAM_START = 8'hDA;
   // converter_control fields
   localparam int SAS_CTL_CHAN_LSB = 0;
   localparam int SAS_CTL_CHAN_W = 3;
   localparam int SAS_CTL_BUSY_BIT = 4;
   // reference_program_start fields
   localparam int SAS_REF_LOW_LSB = 0;
   localparam int SAS_REF_HIGH_LSB = 4;
   localparam int SAS_REF_SEL_W = 4;
   localparam logic [7:0] SAS_REF_DIRECT_VALUE = 8'h00;
   // reset values
   localparam logic [2:0] SAS_CTL_CHAN_RESET = 3'h0;
   localparam logic [7:0] SAS_RESULT_RESET = 8'h00;
   localparam logic [7:0] SAS_REF_RESET = 8'h00;
   localparam logic [7:0] SAS_UNMAPPED_READ = 8'h00;
   // timing in machine cycles and the first trial code
   localparam int SAS_CONV_MC = 15;
   localparam int SAS_SAMPLE_MC = 7;
   localparam logic [3:0] SAS_LAST_SAMPLE_CNT = 4'(SAS_SAMPLE_MC - 1);
   localparam logic [3:0] SAS_LAST_CNT = 4'(SAS_CONV_MC - 1);
   localparam logic [7:0] SAS_TRIAL_FIRST = 8'h80;
endpackage : sas_pkg

// ---- src/sas_sar_core.sv ----
/*
 * successive-approximation register: keeps the trial code and the bit under test.
 * assumes load and step are single-cycle strobes from the sequencer and that
 * above reports held input at or above the current trial level.
 */
`timescale 1ns/10ps
`default_nettype none
module sas_sar_core
   import sas_pkg::*;
#(
   parameter int WIDTH = SAS_DATA_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic load,
   input wire logic step,
   input wire logic above,
   output logic [WIDTH-1:0] trial,
   output logic [WIDTH-1:0] code
);
   typedef struct packed {
      logic [WIDTH-1:0] trial;
      logic [WIDTH-1:0] mask;
   } sas_sar_s;

   sas_sar_s r;
   sas_sar_s next_r;

   always_comb begin
      next_r = r;
      if (load) begin
         next_r.trial = {1'b1, {(WIDTH-1){1'b0}}};
         next_r.mask = {1'b1, {(WIDTH-1){1'b0}}};
      end else if (step) begin
         // drop the tested bit when input is below, then try the next lower one
         if (!above) begin
            next_r.trial = r.trial & ~r.mask;
         end
         next_r.trial = next_r.trial | (r.mask >> 1);
         next_r.mask = r.mask >> 1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign trial = r.trial;
   // decided bits plus the bit under test, kept when above is set and cleared when it is not
   assign code = (above ? r.trial : (r.trial & ~r.mask));
endmodule : sas_sar_core
`default_nettype wire

// ---- src/sas_sequencer.sv ----
/*
 * control logic of an 8-bit successive-approximation converter: three special
 * function registers, sample and hold, eight-step bit decision, reference selection.
 * assumes mc_tick pulses once per core machine cycle on clk, and that the analog
 * comparator output arrives asynchronously on cmp_above.
 */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - writing reference_program_start starts a conversion
// - value 00H selects external references directly, no internal division
// - a write during conversion aborts it and restarts with the new value
// - each finished conversion loads its 8-bit code into conversion_result
// - with no conversion, conversion_result is plain read/write storage
// - a conversion, sampling included, lasts exactly 15 machine cycles
// - duration is fixed, independent of the input value
// - first step compares against half span, deciding the top bit
// - later trial levels are built from bits already decided
// - eight decision steps, most to least significant bit
// - input sampled at start and held until the conversion ends
// - code runs 00H at reference low to FFH at reference high
// - internal low and high each pick one of 16 equal span fractions
// - one of eight analog channels feeds the converter via a multiplexer
module sas_sequencer
   import sas_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic mc_tick,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic cmp_above,
   output logic [2:0] adc_channel,
   output logic sample_track,
   output logic [7:0] trial_code,
   output logic ref_direct,
   output logic [3:0] internal_ref_low,
   output logic [3:0] internal_ref_high,
   output logic conv_busy,
   output logic conv_done
);
   typedef struct packed {
      logic [2:0] chan;
      logic [7:0] refprog;
      logic [7:0] result;
      logic busy;
      logic [3:0] cnt;
      logic done;
      logic [7:0] rdata;
      logic cmp_meta;
      logic cmp_sync;
   } sas_seq_s;

   sas_seq_s r;
   sas_seq_s next_r;
   logic ref_write;
   logic ctl_write;
   logic res_write;
   logic start;
   logic sample_end;
   logic step;
   logic finish;
   logic [7:0] sar_trial;
   logic [7:0] sar_code;

   assign ref_write = sfr_wr && (sfr_addr == SAS_ADDR_REFERENCE_PROGRAM_START);
   assign ctl_write = sfr_wr && (sfr_addr == SAS_ADDR_CONVERTER_CONTROL);
   assign res_write = sfr_wr && (sfr_addr == SAS_ADDR_CONVERSION_RESULT);
   assign start = ref_write;
   // count advances only on machine cycles, never on the input value
   assign sample_end = r.busy && mc_tick && (r.cnt == SAS_LAST_SAMPLE_CNT) && !start;
   assign step = r.busy && mc_tick && (r.cnt > SAS_LAST_SAMPLE_CNT) && !start;
   assign finish = r.busy && mc_tick && (r.cnt == SAS_LAST_CNT) && !start;

   sas_sar_core #(
      .WIDTH(SAS_DATA_W)
   ) u_sar (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .load(sample_end),
      .step(step),
      .above(r.cmp_sync),
      .trial(sar_trial),
      .code(sar_code)
   );

   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      // comparator crosses from the analog side
      next_r.cmp_meta = cmp_above;
      next_r.cmp_sync = r.cmp_meta;
      // channel is not guarded; changing it mid-conversion is the caller's hazard
      if (ctl_write) begin
         next_r.chan = sfr_wdata[SAS_CTL_CHAN_LSB +: SAS_CTL_CHAN_W];
      end
      if (res_write && !r.busy) begin
         next_r.result = sfr_wdata;
      end
      if (start) begin
         next_r.refprog = sfr_wdata;
         next_r.busy = 1'b1;
         next_r.cnt = '0;
      end else if (r.busy && mc_tick) begin
         next_r.cnt = r.cnt + 4'h1;
         if (finish) begin
            next_r.busy = 1'b0;
            next_r.cnt = '0;
            next_r.result = sar_code;
            next_r.done = 1'b1;
         end
      end
      if (sfr_rd) begin
         case (sfr_addr)
            SAS_ADDR_CONVERTER_CONTROL: begin
               next_r.rdata = '0;
               next_r.rdata[SAS_CTL_CHAN_LSB +: SAS_CTL_CHAN_W] = r.chan;
               next_r.rdata[SAS_CTL_BUSY_BIT] = r.busy;
            end
            SAS_ADDR_CONVERSION_RESULT: begin
               next_r.rdata = r.result;
            end
            SAS_ADDR_REFERENCE_PROGRAM_START: begin
               next_r.rdata = r.refprog;
            end
            default: begin
               next_r.rdata = SAS_UNMAPPED_READ;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r.chan <= SAS_CTL_CHAN_RESET;
         r.refprog <= SAS_REF_RESET;
         r.result <= SAS_RESULT_RESET;
         r.busy <= 1'b0;
         r.cnt <= '0;
         r.done <= 1'b0;
         r.rdata <= SAS_UNMAPPED_READ;
         r.cmp_meta <= 1'b0;
         r.cmp_sync <= 1'b0;
      end else if (ce) begin
         r <= next_r;
      end
   end

   assign sfr_rdata = r.rdata;
   assign adc_channel = r.chan;
   // track while sampling, hold from the first decision to the end
   assign sample_track = r.busy && (r.cnt <= SAS_LAST_SAMPLE_CNT);
   assign trial_code = (r.busy && (r.cnt > SAS_LAST_SAMPLE_CNT)) ? sar_trial : 8'h00;
   assign ref_direct = (r.refprog == SAS_REF_DIRECT_VALUE);
   assign internal_ref_low = r.refprog[SAS_REF_LOW_LSB +: SAS_REF_SEL_W];
   assign internal_ref_high = r.refprog[SAS_REF_HIGH_LSB +: SAS_REF_SEL_W];
   assign conv_busy = r.busy;
   assign conv_done = r.done;
endmodule : sas_sequencer
`default_nettype wire

// ---- verif/sas_analog_model.sv ----
/* ideal analog side: eight channel levels and a comparator.
   assumes levels are codes already scaled to the active reference pair. */
`timescale 1ns/10ps
`default_nettype none
module sas_analog_model (
   input wire logic clk,
   input wire logic [63:0] levels,
   input wire logic [2:0] adc_channel,
   input wire logic sample_track,
   input wire logic [7:0] trial_code,
   output logic cmp_above
);
   logic [7:0] held = 8'h00;
   always_ff @(posedge clk) if (sample_track) held <= levels[adc_channel*8 +: 8];
   assign cmp_above = held >= trial_code;
endmodule : sas_analog_model
`default_nettype wire

// ---- verif/sas_seq_properties.sv ----
/* port-level assertions on the converter sequencer.
   assumes one clock domain and an asynchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module sas_seq_properties
   import sas_pkg::*;
(
   input wire logic clk, rst_n, ce, mc_tick, sfr_wr, sfr_rd,
   input wire logic [7:0] sfr_addr, sfr_wdata, trial_code,
   input wire logic [2:0] adc_channel,
   input wire logic [3:0] internal_ref_low, internal_ref_high,
   input wire logic sample_track, ref_direct, conv_busy, conv_done
);
   logic [4:0] n_tick;
   wire logic wr_ref = ce && sfr_wr && sfr_addr == SAS_ADDR_REFERENCE_PROGRAM_START;
   // ticks counted only while busy; the write cycle's tick is ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) n_tick <= 5'h00;
      else if (wr_ref) n_tick <= 5'h00;
      else if (ce && mc_tick && conv_busy) n_tick <= n_tick + 5'h01;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_start_busy: assert property (wr_ref |=> conv_busy && sample_track) else $error("no start");
   chk_restart_run: assert property (conv_busy && wr_ref |=> n_tick == 5'h00 && sample_track)
      else $error("no restart");
   chk_ref_direct: assert property (ref_direct == ({internal_ref_high, internal_ref_low} == 8'h00))
      else $error("direct flag wrong");
   chk_ref_fields: assert property (wr_ref |=> {internal_ref_high, internal_ref_low} == $past(sfr_wdata))
      else $error("reference fields wrong");
   chk_conv_len: assert property (conv_done |-> n_tick == 5'h0F) else $error("length wrong");
   chk_done_busy: assert property (conv_done |-> !conv_busy && $past(conv_busy)) else $error("done w/o busy");
   chk_done_pulse: assert property (conv_done |=> !conv_done) else $error("done too long");
   chk_trial_first: assert property (conv_busy && $fell(sample_track) |-> trial_code == SAS_TRIAL_FIRST)
      else $error("first trial wrong");
   chk_idle_trial: assert property (!conv_busy |-> trial_code == 8'h00) else $error("idle trial");
   chk_chan_sel: assert property (ce && sfr_wr && sfr_addr == SAS_ADDR_CONVERTER_CONTROL
      |=> adc_channel == $past(sfr_wdata[2:0])) else $error("channel wrong");
   cover property (conv_done);
   cover property (conv_busy && wr_ref);
   cover property (sfr_rd && sfr_addr == SAS_ADDR_CONVERSION_RESULT);
endmodule : sas_seq_properties
bind sas_sequencer sas_seq_properties sas_seq_properties_i (.*);
`default_nettype wire

// ---- verif/sas_sequencer_tb_top.sv ----
/* self-checking bench for the converter sequencer.
   assumes the analog model answers at once and a tick every 4 clocks. */
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer_tb_top;
   import sas_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, mc_tick = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, ce = 1'b1;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, trial_code;
   logic [2:0] adc_channel;
   logic [3:0] internal_ref_low, internal_ref_high;
   logic sample_track, ref_direct, conv_busy, conv_done, cmp_above;
   logic [63:0] levels = 64'h0;
   // {reference, channel, level}
   logic [18:0] rows [8] = '{19'h00000, 19'h1E1FF, 19'h78280, 19'h07B7F,
      19'h08C01, 19'h52DAA, 19'h7FE55, 19'h007C3};
   int n_mismatch = 0, samples_checked = 0, cycles = 0;
   sas_sequencer sas_sequencer_i (.*);
   sas_analog_model sas_analog_model_i (.*);
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
      #1 mc_tick = (cycles % 4 == 0);
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk) #1 sfr_wr = 1'b0;
      // idle edge so a following write never re-raises the strobe in the same step
      @(posedge clk) #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge clk) #1 sfr_rd = 1'b0;
      @(posedge clk) #1;
   endtask : rd
   task automatic wait_done;
      for (int k = 0; k < 100 && conv_done !== 1'b1; k++) @(posedge clk) #1;
      chk(conv_done, 1'b1);
   endtask : wait_done
   task automatic summarize;
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   initial begin
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      chk({conv_busy, conv_done, ref_direct, trial_code}, {3'b001, 8'h00});
      rd(SAS_ADDR_CONVERSION_RESULT);
      chk(sfr_rdata, SAS_RESULT_RESET);
      wr(SAS_ADDR_CONVERSION_RESULT, 8'h5A);
      rd(SAS_ADDR_CONVERSION_RESULT);
      chk(sfr_rdata, 8'h5A);
      rd(8'hDB);
      chk(sfr_rdata, SAS_UNMAPPED_READ);
      foreach (rows[i]) begin
         levels[rows[i][10:8]*8 +: 8] = rows[i][7:0];
         wr(SAS_ADDR_CONVERTER_CONTROL, {5'h00, rows[i][10:8]});
         chk(adc_channel, rows[i][10:8]);
         wr(SAS_ADDR_REFERENCE_PROGRAM_START, rows[i][18:11]);
         chk({ref_direct, internal_ref_high, internal_ref_low}, {rows[i][18:11] == 8'h00, rows[i][18:11]});
         wait_done();
         rd(SAS_ADDR_CONVERSION_RESULT);
         chk(sfr_rdata, rows[i][7:0]);
      end
      // restart mid-run, refused result write, input moves after sampling
      levels[15:8] = 8'h3E;
      wr(SAS_ADDR_CONVERTER_CONTROL, 8'h01);
      wr(SAS_ADDR_REFERENCE_PROGRAM_START, 8'h00);
      repeat (20) @(posedge clk);
      #1;
      rd(SAS_ADDR_CONVERTER_CONTROL);
      chk(sfr_rdata, 8'h11);
      wr(SAS_ADDR_REFERENCE_PROGRAM_START, 8'h00);
      wr(SAS_ADDR_CONVERSION_RESULT, 8'hAA);
      for (int k = 0; k < 60 && sample_track !== 1'b0; k++) @(posedge clk) #1;
      levels[15:8] = 8'hC1;
      // clock enable low freezes the conversion mid-run
      ce = 1'b0;
      repeat (8) @(posedge clk) #1;
      chk({conv_busy, conv_done, sample_track}, 3'b100);
      ce = 1'b1;
      wait_done();
      rd(SAS_ADDR_CONVERSION_RESULT);
      chk(sfr_rdata, 8'h3E);
      summarize();
   end
endmodule : sas_sequencer_tb_top
`default_nettype wire
